// ---- hdl/tmcs_pkg.sv ----
// Purpose: Shared constants and types of the torque mode command select block
// Assumes: 10 MHz system clock, APB register access with 32-bit data
// Notes:   Torque values are signed tenths of a percent of rated torque
package tmcs_pkg;

  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned MS_PER_SEC    = 1000;
  localparam int unsigned CYCLES_PER_MS = CLK_HZ / MS_PER_SEC;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL       = 8'h00;
  localparam logic [7:0] ADDR_PRESET_ONE = 8'h04;
  localparam logic [7:0] ADDR_PRESET_TWO = 8'h08;
  localparam logic [7:0] ADDR_PRESET_THR = 8'h0c;
  localparam logic [7:0] ADDR_PRESET_FOU = 8'h10;
  localparam logic [7:0] ADDR_SPEED_LIM  = 8'h14;
  localparam logic [7:0] ADDR_STALL_THR  = 8'h18;
  localparam logic [7:0] ADDR_STALL_DUR  = 8'h1c;
  localparam logic [7:0] ADDR_IN_ASSIGN  = 8'h20;
  localparam logic [7:0] ADDR_STATUS     = 8'h24;

  // Control register field positions
  localparam int unsigned CTRL_SRC_LSB   = 0;
  localparam int unsigned CTRL_LIM_LSB   = 4;
  localparam int unsigned CTRL_DIR_BIT   = 8;
  localparam int unsigned CTRL_TRIG_LSB  = 12;
  localparam int unsigned CTRL_SLOT_LSB  = 16;

  // Torque source encodings
  localparam logic [2:0] SRC_SINGLE  = 3'h0;
  localparam logic [2:0] SRC_MIXED   = 3'h3;
  localparam logic [2:0] SRC_TRIGGER = 3'h4;
  localparam logic [1:0] LIM_INTERNAL = 2'h2;
  localparam logic [1:0] SLOT_INTERNAL = 2'h0;

  // Trigger start methods
  localparam logic [1:0] TRIG_LOW     = 2'h0;
  localparam logic [1:0] TRIG_RISE    = 2'h1;
  localparam logic [1:0] TRIG_FALL    = 2'h2;
  localparam logic [1:0] TRIG_HIGH    = 2'h3;

  // Ranges
  localparam logic signed [15:0] TORQUE_MAX    = 16'sh1388;
  localparam logic [15:0]        SPEED_LIM_MAX = 16'h2710;
  localparam logic [15:0]        STALL_THR_MAX = 16'h01f4;
  localparam logic [15:0]        STALL_DUR_MAX = 16'h01f4;

  // Values after reset
  localparam logic [2:0]  RST_SRC       = 3'h0;
  localparam logic [1:0]  RST_LIM_SRC   = 2'h2;
  localparam logic [1:0]  RST_TRIG      = 2'h1;
  localparam logic [15:0] RST_SPEED_LIM = 16'h0000;
  localparam logic [15:0] RST_STALL_THR = 16'h0005;
  localparam logic [15:0] RST_STALL_DUR = 16'h0078;
  localparam logic [3:0]  TERM_NONE     = 4'hf;
  localparam int unsigned NUM_TERMINALS = 9;

  typedef struct packed {
    logic [7:0] slot;
    logic [1:0] trig_method;
    logic       dir_setting;
    logic [1:0] lim_src;
    logic [2:0] src;
  } tmcs_cfg_type;

  typedef struct packed {
    logic [3:0] trig_term;
    logic [3:0] sel_high_term;
    logic [3:0] sel_low_term;
    logic [3:0] dir_term;
  } tmcs_assign_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_RUN  = 3'b100
  } tmcs_state_type;

endpackage : tmcs_pkg

// ---- hdl/tmcs_stall_timer.sv ----
// Purpose: Measures how long the motor has stayed stalled during a run
// Assumes: stall_in is already a registered level
// Notes:   Any loss of the stall condition restarts the measurement
`timescale 1ns/10ps
module tmcs_stall_timer #(
  parameter int unsigned CYCLES_PER_MS = tmcs_pkg::CYCLES_PER_MS
) (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        run_in,
  input  wire logic        stall_in,
  input  wire logic [15:0] duration_ms,
  output logic             done_ff
);

  logic [23:0] prescale_ff;
  logic [15:0] ms_count_ff;
  logic        ms_tick;

  assign ms_tick = (prescale_ff == 24'(CYCLES_PER_MS - 1));

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      prescale_ff <= 24'h000000;
    end else if (!run_in || !stall_in || ms_tick) begin
      prescale_ff <= 24'h000000;
    end else begin
      prescale_ff <= prescale_ff + 24'h000001;
    end
  end

  // Continuous stall time in whole milliseconds
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ms_count_ff <= 16'h0000;
    end else if (!run_in || !stall_in) begin
      ms_count_ff <= 16'h0000;
    end else if (ms_tick && ms_count_ff != 16'hffff) begin
      ms_count_ff <= ms_count_ff + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= run_in && stall_in && !done_ff && (ms_count_ff >= duration_ms);
    end
  end

endmodule : tmcs_stall_timer

// ---- hdl/tmcs_torque_select.sv ----
// Purpose: Torque mode command selection, speed limiting and single trigger runs
// Assumes: Terminal inputs and motor speed are synchronous to clk_sys
// Notes:   Torque in signed tenths of a percent, speed in signed rpm
//
// Operation
// - Source selector: 0 single preset, 3 four-way mixed, 4 triggered run
// - Speed limit source 2 uses internal limit, default 2
// - Direction setting 0 keeps torque direction, 1 reverses it
// - Slot set to 0 takes its own internal preset one to four
// - Direction switch input reverses torque while active, level sensitive
// - Motor speed never allowed above programmed limit, 0 to 10000 rpm
// - First preset accepts -500.0 to 500.0 percent
// - Trigger function assignable to any input terminal, driven externally
// - Start method: low level, rising, falling, high level; default rising
// - During a run below the limit, output the set maximum torque
// - At the limit during a run, reduce torque to hold speed
// - Stall threshold 0 to 500 rpm, default 5, at or below stalls
// - Stall duration 0 to 500 ms, default 120, continuous
// - After the stall duration the run ends and waits for trigger

`timescale 1ns/10ps
module tmcs_torque_select #(
  parameter int unsigned CYCLES_PER_MS = tmcs_pkg::CYCLES_PER_MS
) (
  input  wire logic                            clk_sys,
  input  wire logic                            reset_n,
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [7:0]                      paddr,
  input  wire logic [31:0]                     pwdata,
  output logic      [31:0]                     prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  input  wire logic [tmcs_pkg::NUM_TERMINALS-1:0] input_terminals,
  input  wire logic signed [15:0]              motor_speed,
  output logic signed [15:0]                   torque_cmd,
  output logic      [15:0]                     speed_limit_out,
  output logic                                 run_active
);

  tmcs_pkg::tmcs_cfg_type    cfg_ff;
  tmcs_pkg::tmcs_assign_type assign_ff;
  tmcs_pkg::tmcs_state_type  state_ff;
  tmcs_pkg::tmcs_state_type  nxt_state;

  // Registers
  logic signed [15:0] preset_ff [4];
  logic        [15:0] speed_lim_ff;
  logic        [15:0] stall_thr_ff;
  logic        [15:0] stall_dur_ff;
  logic        [31:0] prdata_ff;
  logic               pready_ff;
  logic               pslverr_ff;
  logic signed [15:0] torque_ff;
  logic        [15:0] limit_out_ff;
  logic               run_ff;
  logic               trig_prev_ff;
  logic               stall_ff;
  logic               stall_done;

  // Datapath
  logic               wr_en;
  logic               addr_ok;
  logic               dir_in;
  logic               sel_low;
  logic               sel_high;
  logic               trig_in;
  logic               trig_event;
  logic               reverse;
  logic [1:0]         slot_idx;
  logic [1:0]         slot_src;
  logic signed [15:0] base_torque;
  logic signed [15:0] dir_torque;
  logic        [15:0] eff_limit;
  logic        [15:0] speed_abs;
  logic               at_limit;
  logic signed [15:0] nxt_torque;
  logic        [31:0] nxt_rdata;

  // Unsigned clamp used for the speed limit and stall register writes
  function automatic logic [15:0] clamp_u(input logic [31:0] val, input logic [15:0] hi);
    clamp_u = (val[31:16] != 16'h0000 || val[15:0] > hi) ? hi : val[15:0];
  endfunction : clamp_u

  // Signed clamp
  function automatic logic signed [15:0] clamp_torque(input logic [31:0] val);
    logic signed [15:0] v;
    v = signed'(val[15:0]);
    if (v > tmcs_pkg::TORQUE_MAX) begin
      clamp_torque = tmcs_pkg::TORQUE_MAX;
    end else if (v < -tmcs_pkg::TORQUE_MAX) begin
      clamp_torque = -tmcs_pkg::TORQUE_MAX;
    end else begin
      clamp_torque = v;
    end
  endfunction : clamp_torque

  // Picks the level of the terminal that a function is assigned to
  function automatic logic term_level(input logic [3:0] term,
                                      input logic [tmcs_pkg::NUM_TERMINALS-1:0] pins);
    term_level = 1'b0;
    if (term < 4'(tmcs_pkg::NUM_TERMINALS)) begin
      term_level = pins[term];
    end
  endfunction : term_level

  // Magnitude
  function automatic logic [15:0] abs16(input logic signed [15:0] v);
    abs16 = v[15] ? 16'(-v) : 16'(v);
  endfunction : abs16

  // APB decode
  assign wr_en   = psel && penable && pready_ff && pwrite;
  assign addr_ok = (paddr[1:0] == 2'b00) && (paddr <= tmcs_pkg::ADDR_STATUS);

  always_comb begin
    nxt_rdata = 32'h00000000;
    case (paddr)
      tmcs_pkg::ADDR_CTRL: begin
        nxt_rdata[tmcs_pkg::CTRL_SRC_LSB +: 3]  = cfg_ff.src;
        nxt_rdata[tmcs_pkg::CTRL_LIM_LSB +: 2]  = cfg_ff.lim_src;
        nxt_rdata[tmcs_pkg::CTRL_DIR_BIT]       = cfg_ff.dir_setting;
        nxt_rdata[tmcs_pkg::CTRL_TRIG_LSB +: 2] = cfg_ff.trig_method;
        nxt_rdata[tmcs_pkg::CTRL_SLOT_LSB +: 8] = cfg_ff.slot;
      end
      tmcs_pkg::ADDR_PRESET_ONE: nxt_rdata = 32'(preset_ff[0]);
      tmcs_pkg::ADDR_PRESET_TWO: nxt_rdata = 32'(preset_ff[1]);
      tmcs_pkg::ADDR_PRESET_THR: nxt_rdata = 32'(preset_ff[2]);
      tmcs_pkg::ADDR_PRESET_FOU: nxt_rdata = 32'(preset_ff[3]);
      tmcs_pkg::ADDR_SPEED_LIM:  nxt_rdata = {16'h0000, speed_lim_ff};
      tmcs_pkg::ADDR_STALL_THR:  nxt_rdata = {16'h0000, stall_thr_ff};
      tmcs_pkg::ADDR_STALL_DUR:  nxt_rdata = {16'h0000, stall_dur_ff};
      tmcs_pkg::ADDR_IN_ASSIGN:  nxt_rdata = {16'h0000, assign_ff};
      tmcs_pkg::ADDR_STATUS:     nxt_rdata = {torque_ff, 12'h000, run_ff, state_ff};
      default:                   nxt_rdata = 32'h00000000;
    endcase
  end

  // Answer in the first access cycle; data and error prepared in setup
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= psel && !penable;
      pslverr_ff <= psel && !penable && !addr_ok;
      if (psel && !penable) begin
        prdata_ff <= nxt_rdata;
      end
    end
  end

  // Control word
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cfg_ff.src         <= tmcs_pkg::RST_SRC;
      cfg_ff.lim_src     <= tmcs_pkg::RST_LIM_SRC;
      cfg_ff.dir_setting <= 1'b0;
      cfg_ff.trig_method <= tmcs_pkg::RST_TRIG;
      cfg_ff.slot        <= 8'h00;
    end else if (wr_en && paddr == tmcs_pkg::ADDR_CTRL) begin
      cfg_ff.src         <= pwdata[tmcs_pkg::CTRL_SRC_LSB +: 3];
      cfg_ff.lim_src     <= pwdata[tmcs_pkg::CTRL_LIM_LSB +: 2];
      cfg_ff.dir_setting <= pwdata[tmcs_pkg::CTRL_DIR_BIT];
      cfg_ff.trig_method <= pwdata[tmcs_pkg::CTRL_TRIG_LSB +: 2];
      cfg_ff.slot        <= pwdata[tmcs_pkg::CTRL_SLOT_LSB +: 8];
    end
  end

  // Presets
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 4; i++) begin
        preset_ff[i] <= 16'sh0000;
      end
    end else if (wr_en && paddr >= tmcs_pkg::ADDR_PRESET_ONE
                 && paddr <= tmcs_pkg::ADDR_PRESET_FOU) begin
      preset_ff[2'(paddr[7:2] - 6'h01)] <= clamp_torque(pwdata);
    end
  end

  // Ranged settings and input terminal assignment
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      speed_lim_ff <= tmcs_pkg::RST_SPEED_LIM;
      stall_thr_ff <= tmcs_pkg::RST_STALL_THR;
      stall_dur_ff <= tmcs_pkg::RST_STALL_DUR;
      assign_ff    <= {4{tmcs_pkg::TERM_NONE}};
    end else if (wr_en) begin
      if (paddr == tmcs_pkg::ADDR_SPEED_LIM) begin
        speed_lim_ff <= clamp_u(pwdata, tmcs_pkg::SPEED_LIM_MAX);
      end
      if (paddr == tmcs_pkg::ADDR_STALL_THR) begin
        stall_thr_ff <= clamp_u(pwdata, tmcs_pkg::STALL_THR_MAX);
      end
      if (paddr == tmcs_pkg::ADDR_STALL_DUR) begin
        stall_dur_ff <= clamp_u(pwdata, tmcs_pkg::STALL_DUR_MAX);
      end
      if (paddr == tmcs_pkg::ADDR_IN_ASSIGN) begin
        assign_ff <= pwdata[15:0];
      end
    end
  end

  // Terminal function routing
  assign dir_in   = term_level(assign_ff.dir_term, input_terminals);
  assign sel_low  = term_level(assign_ff.sel_low_term, input_terminals);
  assign sel_high = term_level(assign_ff.sel_high_term, input_terminals);
  assign trig_in  = term_level(assign_ff.trig_term, input_terminals);

  // Trigger history
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      trig_prev_ff <= 1'b0;
    end else begin
      trig_prev_ff <= trig_in;
    end
  end

  // Start condition
  always_comb begin
    case (cfg_ff.trig_method)
      tmcs_pkg::TRIG_LOW:  trig_event = !trig_in;
      tmcs_pkg::TRIG_RISE: trig_event = trig_in && !trig_prev_ff;
      tmcs_pkg::TRIG_FALL: trig_event = !trig_in && trig_prev_ff;
      tmcs_pkg::TRIG_HIGH: trig_event = trig_in;
      default:             trig_event = 1'b0;
    endcase
  end

  // Torque source selection
  assign slot_idx = {sel_high, sel_low};
  assign slot_src = cfg_ff.slot[2*slot_idx +: 2];
  assign reverse  = cfg_ff.dir_setting ^ dir_in;

  always_comb begin
    case (cfg_ff.src)
      tmcs_pkg::SRC_SINGLE:  base_torque = preset_ff[0];
      tmcs_pkg::SRC_MIXED:   base_torque = (slot_src == tmcs_pkg::SLOT_INTERNAL)
                                           ? preset_ff[slot_idx] : 16'sh0000;
      tmcs_pkg::SRC_TRIGGER: base_torque = (state_ff == tmcs_pkg::ST_RUN)
                                           ? preset_ff[0] : 16'sh0000;
      default:               base_torque = 16'sh0000;
    endcase
  end

  // Direction
  assign dir_torque = reverse ? 16'(-base_torque) : base_torque;

  // Reserved limit sources leave no speed allowed
  assign eff_limit = (cfg_ff.lim_src == tmcs_pkg::LIM_INTERNAL) ? speed_lim_ff
                                                                : 16'h0000;
  // Limit check
  assign speed_abs = abs16(motor_speed);
  assign at_limit  = (speed_abs >= eff_limit)
                     && (motor_speed == 16'sh0000 || motor_speed[15] == dir_torque[15]);

  // Torque pushing further past the limit is withdrawn so speed holds there
  assign nxt_torque = (at_limit && dir_torque != 16'sh0000) ? 16'sh0000
                                                           : dir_torque;

  // Stall flag
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      stall_ff <= 1'b0;
    end else begin
      stall_ff <= (speed_abs <= stall_thr_ff);
    end
  end

  // Stall timing
  tmcs_stall_timer #(
    .CYCLES_PER_MS (CYCLES_PER_MS)
  ) u_stall_timer (
    .clk_sys     (clk_sys),
    .reset_n     (reset_n),
    .run_in      (state_ff == tmcs_pkg::ST_RUN),
    .stall_in    (stall_ff),
    .duration_ms (stall_dur_ff),
    .done_ff     (stall_done)
  );

  // Single trigger run sequencing
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      tmcs_pkg::ST_IDLE: begin
        if (cfg_ff.src == tmcs_pkg::SRC_TRIGGER) begin
          nxt_state = tmcs_pkg::ST_WAIT;
        end
      end
      tmcs_pkg::ST_WAIT: begin
        if (cfg_ff.src != tmcs_pkg::SRC_TRIGGER) begin
          nxt_state = tmcs_pkg::ST_IDLE;
        end else if (trig_event) begin
          nxt_state = tmcs_pkg::ST_RUN;
        end
      end
      tmcs_pkg::ST_RUN: begin
        if (cfg_ff.src != tmcs_pkg::SRC_TRIGGER) begin
          nxt_state = tmcs_pkg::ST_IDLE;
        end else if (stall_done) begin
          nxt_state = tmcs_pkg::ST_WAIT;
        end
      end
      default: nxt_state = tmcs_pkg::ST_IDLE;
    endcase
  end

  // Run state
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= tmcs_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Output registers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      torque_ff    <= 16'sh0000;
      limit_out_ff <= 16'h0000;
      run_ff       <= 1'b0;
    end else begin
      torque_ff    <= nxt_torque;
      limit_out_ff <= eff_limit;
      run_ff       <= (nxt_state == tmcs_pkg::ST_RUN);
    end
  end

  // Ports
  assign prdata          = prdata_ff;
  assign pready          = pready_ff;
  assign pslverr         = pslverr_ff;
  assign torque_cmd      = torque_ff;
  assign speed_limit_out = limit_out_ff;
  assign run_active      = run_ff;

endmodule : tmcs_torque_select

// ---- test/tmcs_torque_chk.sv ----
// Purpose: Port assertions for the torque mode command select block
// Assumes: Bound to tmcs_torque_select, single clk_sys domain
// Notes:   Stall counter bounds a run whose speed sits at zero
`timescale 1ns/10ps
module tmcs_torque_chk #(
  parameter int unsigned CYCLES_PER_MS = tmcs_pkg::CYCLES_PER_MS
) (
  input wire logic                                 clk_sys,
  input wire logic                                 reset_n,
  input wire logic                                 psel,
  input wire logic                                 penable,
  input wire logic                                 pwrite,
  input wire logic        [7:0]                    paddr,
  input wire logic        [31:0]                   pwdata,
  input wire logic        [31:0]                   prdata,
  input wire logic                                 pready,
  input wire logic                                 pslverr,
  input wire logic        [tmcs_pkg::NUM_TERMINALS-1:0] input_terminals,
  input wire logic signed [15:0]                   motor_speed,
  input wire logic signed [15:0]                   torque_cmd,
  input wire logic        [15:0]                   speed_limit_out,
  input wire logic                                 run_active
);
  localparam int unsigned STALL_MAX = 500 * CYCLES_PER_MS + 8;
  logic [31:0] stall_cnt_ff;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  // Consecutive cycles of a run with the shaft at rest
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      stall_cnt_ff <= 32'h0;
    end else if (run_active && motor_speed == 16'sh0000) begin
      stall_cnt_ff <= stall_cnt_ff + 32'h1;
    end else begin
      stall_cnt_ff <= 32'h0;
    end
  end

  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  ready_one_cycle_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  unmapped_err_a: assert property (psel && penable && pready &&
    (paddr > 8'h24 || paddr[1:0] != 2'h0) |-> pslverr)
    else $error("unmapped access without pslverr");
  limit_range_a: assert property (speed_limit_out <= tmcs_pkg::SPEED_LIM_MAX)
    else $error("speed limit above range");
  torque_range_a: assert property (torque_cmd <= tmcs_pkg::TORQUE_MAX &&
    torque_cmd >= -tmcs_pkg::TORQUE_MAX)
    else $error("torque command out of range");
  limit_cut_a: assert property ((motor_speed > 16'sh0000 &&
    motor_speed >= $signed({1'b0, speed_limit_out})) [*3] |-> torque_cmd <= 16'sh0000)
    else $error("torque drives speed past limit");
  run_end_zero_a: assert property ($fell(run_active) |=>
    torque_cmd == 16'sh0000 || run_active)
    else $error("torque left on after run end");
  stall_bound_a: assert property (stall_cnt_ff <= STALL_MAX)
    else $error("run outlived stall duration");

  cover property ($rose(run_active));
  cover property ($fell(run_active));
  cover property (pready && pslverr);
endmodule : tmcs_torque_chk

// ---- test/tmcs_drive_env.sv ----
// Purpose: Input terminals and motor speed seen by the block
// Assumes: Bench sets wanted levels; model registers them one cycle later
// Notes:   Unassigned terminals carry a changing pattern
`timescale 1ns/10ps
module tmcs_drive_env (
  input  wire logic               clk_sys,
  input  wire logic               reset_n,
  input  wire logic [3:0]         term_set,
  input  wire logic signed [15:0] speed_set,
  output logic [8:0]              input_terminals,
  output logic signed [15:0]      motor_speed
);
  logic [3:0]         term_ff;
  logic [4:0]         noise_ff;
  logic signed [15:0] speed_ff;

  // External switches drive the assigned trigger and select terminals
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      term_ff <= 4'h0;
    end else begin
      term_ff <= term_set;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      noise_ff <= 5'h0;
    end else begin
      noise_ff <= noise_ff + 5'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      speed_ff <= 16'sh0000;
    end else begin
      speed_ff <= speed_set;
    end
  end

  assign input_terminals = {noise_ff, term_ff};
  assign motor_speed     = speed_ff;
endmodule : tmcs_drive_env

// ---- test/tmcs_torque_select_tb.sv ----
// Purpose: Self-checking bench for the torque mode command select block
// Assumes: Terminals 0 dir, 1 select low, 2 select high, 3 trigger
// Notes:   CYCLES_PER_MS shortened to 10, stall duration set to 2 ms
`timescale 1ns/10ps
module tmcs_torque_select_tb;
  logic               clk_sys, reset_n, psel, penable, pwrite, pready, pslverr, run_active, er;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, rd;
  logic [8:0]         input_terminals;
  logic signed [15:0] motor_speed, torque_cmd, speed_set, pre [4];
  logic [15:0]        speed_limit_out;
  logic [3:0]         term_set;
  logic               lvl;
  int                 error_cnt, checks_done, cyc_cnt;

  tmcs_torque_select #(.CYCLES_PER_MS(10)) tmcs_torque_select_i (.clk_sys(clk_sys),
    .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .input_terminals(input_terminals), .motor_speed(motor_speed),
    .torque_cmd(torque_cmd), .speed_limit_out(speed_limit_out), .run_active(run_active));
  tmcs_drive_env tmcs_drive_env_i (.clk_sys(clk_sys), .reset_n(reset_n),
    .term_set(term_set), .speed_set(speed_set), .input_terminals(input_terminals),
    .motor_speed(motor_speed));

  function automatic logic [31:0] ctl(logic [2:0] s, logic [1:0] m, logic d,
                                      logic [7:0] sl, logic [1:0] lim);
    return {8'h00, sl, 2'h0, m, 3'h0, d, 2'h0, lim, 1'h0, s};
  endfunction : ctl

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) error_cnt++;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc

  task automatic rdl(input logic [7:0] a, input logic [15:0] exp);
    apb(1'b0, a, 32'h0);
    chk({16'h0, rd[15:0]}, {16'h0, exp});
  endtask : rdl

  task automatic drv(input logic [3:0] t, input logic signed [15:0] s);
    @(posedge clk_sys);
    term_set  <= t;
    speed_set <= s;
  endtask : drv

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc

  task automatic tchk(input logic signed [15:0] exp);
    chk({16'h0, torque_cmd}, {16'h0, exp});
  endtask : tchk

  task automatic wait_run(input logic v);
    int n;
    n = 0;
    while (run_active !== v && n < 200) begin
      @(posedge clk_sys);
      n++;
    end
    chk({31'h0, run_active}, {31'h0, v});
  endtask : wait_run

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Whole run needs well under this many cycles
  always @(posedge clk_sys) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end

  initial begin
    {reset_n, psel, penable, pwrite, paddr, pwdata, term_set, speed_set} = '0;
    {error_cnt, checks_done, cyc_cnt} = '0;
    pre = '{16'sh0064, 16'sh00c8, -16'sh012c, 16'sh0190};
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    rdc(tmcs_pkg::ADDR_CTRL, 32'h00001020);
    rdc(tmcs_pkg::ADDR_SPEED_LIM, 32'h0);
    rdc(tmcs_pkg::ADDR_STALL_THR, 32'h5);
    rdc(tmcs_pkg::ADDR_STALL_DUR, 32'h78);
    rdc(tmcs_pkg::ADDR_IN_ASSIGN, 32'hffff);
    rdc(8'h40, 32'h0);
    chk({31'h0, er}, 32'h1);
    tchk(16'sh0000);
    $display("test reset done");
    wr(tmcs_pkg::ADDR_PRESET_ONE, 32'h2000);
    rdl(tmcs_pkg::ADDR_PRESET_ONE, 16'h1388);
    wr(tmcs_pkg::ADDR_PRESET_ONE, 32'he000);
    rdl(tmcs_pkg::ADDR_PRESET_ONE, 16'hec78);
    wr(tmcs_pkg::ADDR_SPEED_LIM, 32'h4e20);
    rdl(tmcs_pkg::ADDR_SPEED_LIM, 16'h2710);
    wr(tmcs_pkg::ADDR_STALL_THR, 32'h258);
    rdl(tmcs_pkg::ADDR_STALL_THR, 16'h01f4);
    wr(tmcs_pkg::ADDR_STALL_DUR, 32'h258);
    rdl(tmcs_pkg::ADDR_STALL_DUR, 16'h01f4);
    $display("test clamp done");
    for (int i = 0; i < 4; i++) wr(tmcs_pkg::ADDR_PRESET_ONE + 8'(4 * i), {16'h0, pre[i]});
    wr(tmcs_pkg::ADDR_SPEED_LIM, 32'h3e8);
    wr(tmcs_pkg::ADDR_IN_ASSIGN, 32'h3210);
    wr(tmcs_pkg::ADDR_STALL_THR, 32'h5);
    wr(tmcs_pkg::ADDR_STALL_DUR, 32'h2);
    for (int i = 0; i < 4; i++) begin
      wr(tmcs_pkg::ADDR_CTRL, ctl(3'h0, 2'h1, i[0], 8'h00, 2'h2));
      drv({3'h0, i[1]}, 16'sh0000);
      cyc(4);
      tchk((i[0] ^ i[1]) ? -pre[0] : pre[0]);
    end
    drv(4'h0, -16'sh03e8);
    cyc(4);
    tchk(16'sh0000);
    chk({16'h0, speed_limit_out}, 32'h3e8);
    drv(4'h0, -16'sh03e7);
    cyc(4);
    tchk(-pre[0]);
    wr(tmcs_pkg::ADDR_CTRL, ctl(3'h0, 2'h1, 1'b0, 8'h00, 2'h0));
    cyc(3);
    chk({16'h0, speed_limit_out}, 32'h0);
    $display("test single done");
    wr(tmcs_pkg::ADDR_CTRL, ctl(3'h3, 2'h1, 1'b0, 8'h00, 2'h2));
    for (int i = 0; i < 4; i++) begin
      drv({1'b0, i[1], i[0], 1'b0}, 16'sh0000);
      cyc(4);
      tchk(pre[i]);
    end
    wr(tmcs_pkg::ADDR_CTRL, ctl(3'h3, 2'h1, 1'b0, 8'h01, 2'h2));
    drv(4'h0, 16'sh0000);
    cyc(4);
    tchk(16'sh0000);
    for (int s = 1; s < 3; s++) begin
      wr(tmcs_pkg::ADDR_CTRL, ctl(3'(s), 2'h1, 1'b0, 8'h00, 2'h2));
      cyc(3);
      tchk(16'sh0000);
    end
    $display("test mixed done");
    for (int m = 0; m < 4; m++) begin
      lvl = (m == 0 || m == 2);
      drv({lvl, 3'h0}, (m == 1) ? 16'sh0006 : 16'sh0000);
      wr(tmcs_pkg::ADDR_CTRL, ctl(3'h4, 2'(m), 1'b0, 8'h00, 2'h2));
      cyc(3);
      chk({31'h0, run_active}, 32'h0);
      drv({~lvl, 3'h0}, (m == 1) ? 16'sh0006 : 16'sh0000);
      wait_run(1'b1);
      cyc(1);
      tchk(pre[0]);
      if (m == 1) begin
        drv(4'h8, 16'sh03e8);
        cyc(4);
        tchk(16'sh0000);
        drv(4'h0, 16'sh0006);
        cyc(60);
        chk({31'h0, run_active}, 32'h1);
        drv(4'h8, 16'sh0005);
        cyc(10);
        chk({31'h0, run_active}, 32'h1);
      end else begin
        drv({lvl, 3'h0}, 16'sh0000);
      end
      wait_run(1'b0);
      cyc(5);
      chk({31'h0, run_active}, 32'h0);
      tchk(16'sh0000);
      wr(tmcs_pkg::ADDR_CTRL, ctl(3'h0, 2'h1, 1'b0, 8'h00, 2'h2));
    end
    $display("test trigger done");
    end_of_test();
  end
endmodule : tmcs_torque_select_tb

bind tmcs_torque_select tmcs_torque_chk #(.CYCLES_PER_MS(CYCLES_PER_MS)) chk_i (
  .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .input_terminals(input_terminals), .motor_speed(motor_speed),
  .torque_cmd(torque_cmd), .speed_limit_out(speed_limit_out), .run_active(run_active));
